/* verilog/madp_pkg.sv */
// shared constants and types for the motor angle / position detect block
package madp_pkg;

    // ----------
    // register indices (byte address is four times the index)
    // ----------
    localparam logic [13:0] IDX_PD_CTRL_A = 14'h1fa0;
    localparam logic [13:0] IDX_PD_CTRL_B = 14'h1fa1;
    localparam logic [13:0] IDX_PD_STATUS = 14'h1fa2;
    localparam logic [13:0] IDX_SMP_DELAY = 14'h1fa3;
    localparam logic [13:0] IDX_ANG_CTRL = 14'h1fc0;
    localparam logic [13:0] IDX_ANG_PERIOD = 14'h1fc2;
    localparam logic [13:0] IDX_ANG_VALUE = 14'h1fc4;
    localparam logic [13:0] IDX_AMPLITUDE = 14'h1fc5;
    localparam logic [13:0] IDX_SINE_PORT = 14'h1fc6;
    localparam logic [13:0] IDX_MOD_PERIOD = 14'h1fc7;
    localparam logic [13:0] IDX_CMP_U = 14'h1fc8;
    localparam logic [13:0] IDX_CMP_V = 14'h1fc9;
    localparam logic [13:0] IDX_CMP_W = 14'h1fca;
    localparam logic [13:0] IDX_REF_PAT = 14'h1fcb;

    // ----------
    // field positions
    // ----------
    localparam int ANG_DIR_BIT = 7;
    localparam int ANG_ORDER_BIT = 6;
    localparam int ANG_CLK_LSB = 4;
    localparam int ANG_MOD3_BIT = 3;
    localparam int ANG_XFER_BIT = 2;
    localparam int ANG_WAVEFORM_ENABLE_A_BIT = 1;
    localparam int ANG_EN_BIT = 0;
    localparam int PDA_STOP_BIT = 7;
    localparam int PDA_START_BIT = 6;
    localparam int PDA_T3_BIT = 5;
    localparam int PDA_T2_BIT = 4;
    localparam int PDA_ONEPIN_BIT = 3;
    localparam int PDA_RESTART_BIT = 2;
    localparam int PDA_UNMATCH_BIT = 1;
    localparam int PDA_EN_BIT = 0;
    localparam int PDB_CLK_LSB = 6;
    localparam int PDB_MODE_LSB = 4;
    localparam int PERIOD_CORR_LSB = 12;

    // ----------
    // reset values and counts
    // ----------
    localparam logic [7:0] ANG_CTRL_RST = 8'h00;
    localparam logic [15:0] ANG_PERIOD_RST = 16'h0010;
    localparam logic [11:0] PERIOD_MIN = 12'h010;
    localparam logic [8:0] ANGLE_STEPS = 9'h180;
    localparam logic [8:0] ANGLE_LAST = 9'h17f;
    localparam logic [8:0] ANGLE_HALF = 9'h0c0;
    localparam logic [8:0] PHASE_120 = 9'h080;
    localparam logic [8:0] PHASE_240 = 9'h100;
    localparam int DELAY_UNIT_CYC = 8;
    localparam int ANG_DIV_BASE = 3;
    localparam int SMP_DIV_BASE = 2;

    // ----------
    // modes and states
    // ----------
    typedef enum logic [1:0] {
        SMP_PWM_ON = 2'b00,
        SMP_ALWAYS = 2'b01,
        SMP_LOWER_ON = 2'b10,
        SMP_RSVD = 2'b11
    } madp_smp_mode_t;

    typedef enum logic [1:0] {
        PD_IDLE = 2'b00,
        PD_DELAY = 2'b01,
        PD_SAMPLE = 2'b10
    } madp_pd_state_t;

    typedef struct packed {
        logic [15:0] u;
        logic [15:0] v;
        logic [15:0] w;
    } madp_duty_t;

    typedef struct packed {
        logic u;
        logic v;
        logic w;
    } madp_pos_t;

endpackage : madp_pkg

/* verilog/madp_prescale.sv */
// power-of-two prescaler giving a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module madp_prescale import madp_pkg::*; #(
    parameter int BASE = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic clr,
    input wire logic [1:0] sel,
    // tick out
    output logic tick
);
    initial begin
        if (BASE < 1 || BASE + 3 > 7) $error("madp_prescale: BASE out of range");
    end

    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } madp_pre_state_t;

    madp_pre_state_t s_q, s_d;
    logic [6:0] mask;

    always_comb begin
        mask = 7'((8'h01 << (BASE + int'(sel))) - 8'h01);
        s_d = s_q;
        s_d.cnt = clr ? 7'h00 : s_q.cnt + 7'h01;
        s_d.tick = !clr && ((s_q.cnt & mask) == mask);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : madp_prescale
`default_nettype wire

/* verilog/madp_waveform.sv */
// sine table and three-phase waveform arithmetic
`timescale 1ns/1ps
`default_nettype none
module madp_waveform import madp_pkg::*; (
    // clock
    input wire logic ref_clk,
    // sine table write port
    input wire logic tbl_we,
    input wire logic [8:0] tbl_addr,
    input wire logic [7:0] tbl_data,
    // arithmetic inputs
    input wire logic [8:0] angle,
    input wire logic phase_order_select,
    input wire logic modulation_phase_select,
    input wire logic [7:0] amp,
    input wire logic [15:0] mod_period,
    // results
    output madp_duty_t duty
);
    logic [7:0] table_q [384];

    function automatic logic [8:0] ang_add(input logic [8:0] a,
                                            input logic [8:0] off);
        logic [9:0] sum;
        sum = {1'b0, a} + {1'b0, off};
        if (sum >= {1'b0, ANGLE_STEPS}) begin
            sum = sum - {1'b0, ANGLE_STEPS};
        end
        return sum[8:0];
    endfunction : ang_add

    // in 3-phase mode, plus sign in the first half turn, minus in the second
    function automatic logic [15:0] wave(input logic [8:0] a);
        logic [15:0] prod;
        prod = 16'(table_q[a]) * 16'(amp);
        if (!modulation_phase_select) begin
            return prod;
        end
        if (a < ANGLE_HALF) begin
            return (mod_period >> 1) + (prod >> 1);
        end
        return (mod_period >> 1) - (prod >> 1);
    endfunction : wave

    always_ff @(posedge ref_clk) begin
        if (tbl_we && tbl_addr <= ANGLE_LAST) begin
            table_q[tbl_addr] <= tbl_data;
        end
    end

    always_comb begin
        duty.u = wave(angle);
        duty.v = wave(ang_add(angle,
                              phase_order_select ? PHASE_240 : PHASE_120));
        duty.w = wave(ang_add(angle,
                              phase_order_select ? PHASE_120 : PHASE_240));
    end
endmodule : madp_waveform
`default_nettype wire

/* verilog/madp_core.sv */
// angle timer, waveform transfer and position detection with apb registers
//
// How it works
// R01: angle counter counts up when direction bit is 0, down when 1
// R02: phase order 0 puts V,W at +120/+240 from U; 1 at -120/-240
// R03: angle clock code 00..11 selects fc/8, fc/16, fc/32, fc/64
// R04: software changes angle clock only with the timer disabled
// R05: modulation bit picks 2-phase (0) or 3-phase (1) waveform
// R06: transfer bit 1 copies results to pwm compare outputs, 0 holds them
// R07: waveform_enable_a enable runs arithmetic; results readable in U, V, W compares
// R08: timer enable starts counting; clearing stops it and zeroes count
// R09: period is (m + n/16) x 384 clocks, m at least 010h, n 0..15
// R10: in each 16 angle steps, n steps last m+1 clocks, rest m
// R11: software avoids read-modify-write on write-only ports
// R12: software sets port output latches to 1 before using pins
// R13: where field 00 means current pwm pulse, 11 preceding pulse
// R14: status bit 3 reads 1 while sampling, 0 when idle
// R15: unmatch mode keeps sampled W, V, U in status bits 2..0
// R16: sampling clock code 00..11 selects fc/4, fc/8, fc/16, fc/32
// R17: sampling mode: pwm on (00), always (01), lower phases on (10)
// R18: 1 to 15 consecutive matching samples declare a detection
// R19: writing 1 to start bit 6 starts, stop bit stops; 0 ignored
// R20: enabled timer 3 event stops sampling, timer 2 event starts it
// R21: pin-count bit 0 compares three inputs, 1 only the U input
// R22: restart bit 0 carries match count over on-times, 1 restarts it
// R23: detection mode bit 0 ordinary, 1 unmatch detection
// R24: enable bit 0 set starts sampling; clearing disables detection
// R25: sampling start is delayed by n x 8 system clocks, n = bits 6..0
// R26: every angle control bit is readable and writable
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module madp_core import madp_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // position sensors and pwm state
    input wire madp_pos_t pos_in,
    input wire logic pwm_on,
    input wire logic lower_on,
    input wire logic timer2_event,
    input wire logic timer3_event,
    // results
    output madp_duty_t pwm_duty,
    output logic [8:0] electrical_angle_value,
    output logic pos_detect,
    output logic sampling_active
);
    // ----------
    // state
    // ----------
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [5:0] pda;
        logic [7:0] pdb;
        logic [6:0] sdl;
        logic [7:0] atc;
        logic [15:0] aps;
        logic [8:0] angle;
        logic [7:0] amp;
        logic [15:0] mod_prd;
        logic [2:0] ref_pat;
        logic [11:0] sub;
        logic [3:0] grp;
        madp_pd_state_t pd;
        logic [9:0] dly;
        logic [3:0] mcnt;
        logic carried;
        logic [1:0] where;
        logic [2:0] unm;
        logic pwm_on_q;
        logic detect;
        madp_duty_t waveform_enable_a;
        madp_duty_t duty;
    } madp_core_state_t;

    madp_core_state_t s_q, s_d;

    logic ang_tick;
    logic smp_tick;
    madp_duty_t wave_res;
    logic [13:0] idx;
    logic acc_ok;
    logic wr_en;
    logic rd_en;
    logic tbl_we;

    assign idx = paddr[15:2];
    assign acc_ok = paddr[1:0] == 2'b00;
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && !penable;
    assign tbl_we = wr_en && idx == IDX_SINE_PORT;

    function automatic logic idx_mapped(input logic [13:0] i);
        unique case (i)
            IDX_PD_CTRL_A, IDX_PD_CTRL_B, IDX_PD_STATUS, IDX_SMP_DELAY,
            IDX_ANG_CTRL, IDX_ANG_PERIOD, IDX_ANG_VALUE, IDX_AMPLITUDE,
            IDX_SINE_PORT, IDX_MOD_PERIOD, IDX_CMP_U, IDX_CMP_V, IDX_CMP_W,
            IDX_REF_PAT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : idx_mapped

    // ----------
    // dividers and arithmetic
    // ----------
    madp_prescale #(.BASE(ANG_DIV_BASE)) u_ang_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(!s_q.atc[ANG_EN_BIT]),
        .sel(s_q.atc[ANG_CLK_LSB +: 2]), // [R03]
        .tick(ang_tick)
    );

    madp_prescale #(.BASE(SMP_DIV_BASE)) u_smp_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(s_q.pd != PD_SAMPLE),
        .sel(s_q.pdb[PDB_CLK_LSB +: 2]), // [R16]
        .tick(smp_tick)
    );

    madp_waveform u_wave (
        .ref_clk(ref_clk),
        .tbl_we(tbl_we),
        .tbl_addr(s_q.angle),
        .tbl_data(pwdata[7:0]),
        .angle(s_q.angle),
        .phase_order_select(s_q.atc[ANG_ORDER_BIT]), // [R02]
        .modulation_phase_select(s_q.atc[ANG_MOD3_BIT]), // [R05]
        .amp(s_q.amp),
        .mod_period(s_q.mod_prd),
        .duty(wave_res)
    );

    // ----------
    // next state
    // ----------
    always_comb begin
        logic [11:0] base_m;
        logic [11:0] lim;
        logic [2:0] mask;
        logic [2:0] smp;
        logic gate;
        logic start;
        logic stop;
        logic pwm_rise;
        logic [3:0] need;
        base_m = 12'h000;
        lim = 12'h000;
        mask = 3'b000;
        smp = 3'b000;
        gate = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        pwm_rise = 1'b0;
        need = 4'h0;
        s_d = s_q;
        s_d.detect = 1'b0;
        s_d.pwm_on_q = pwm_on;

        // apb: data is prepared in setup, answered in the first access
        s_d.pready = rd_en;
        s_d.pslverr = rd_en && !(acc_ok && idx_mapped(idx));
        s_d.prdata = 32'h0000_0000;
        if (rd_en && acc_ok) begin
            unique case (idx)
                IDX_PD_CTRL_A: s_d.prdata = {26'h0, s_q.pda};
                IDX_PD_CTRL_B: s_d.prdata = {24'h0, s_q.pdb};
                IDX_PD_STATUS: s_d.prdata = {26'h0, s_q.where, // [R13]
                    s_q.pd != PD_IDLE, s_q.unm}; // [R14] [R15]
                IDX_SMP_DELAY: s_d.prdata = {25'h0, s_q.sdl};
                IDX_ANG_CTRL: s_d.prdata = {24'h0, s_q.atc}; // [R26]
                IDX_ANG_PERIOD: s_d.prdata = {16'h0, s_q.aps};
                IDX_ANG_VALUE: s_d.prdata = {23'h0, s_q.angle};
                IDX_AMPLITUDE: s_d.prdata = {24'h0, s_q.amp};
                IDX_MOD_PERIOD: s_d.prdata = {16'h0, s_q.mod_prd};
                IDX_CMP_U: s_d.prdata = {16'h0, s_q.waveform_enable_a.u}; // [R07]
                IDX_CMP_V: s_d.prdata = {16'h0, s_q.waveform_enable_a.v}; // [R07]
                IDX_CMP_W: s_d.prdata = {16'h0, s_q.waveform_enable_a.w}; // [R07]
                IDX_REF_PAT: s_d.prdata = {29'h0, s_q.ref_pat};
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end

        // ----------
        // angle timer
        // ----------
        base_m = s_q.aps[11:0] < PERIOD_MIN ? PERIOD_MIN : s_q.aps[11:0];
        // n of every 16 steps take one extra clock
        lim = (s_q.grp < s_q.aps[PERIOD_CORR_LSB +: 4]) ?
            base_m + 12'h001 : base_m; // [R10] [R09]
        // a stopped timer keeps its angle so the sine table can be loaded
        if (!s_q.atc[ANG_EN_BIT]) begin
            s_d.sub = 12'h000;
            s_d.grp = 4'h0;
        end else if (ang_tick) begin
            if (s_q.sub >= lim - 12'h001) begin
                s_d.sub = 12'h000;
                s_d.grp = s_q.grp + 4'h1;
                if (!s_q.atc[ANG_DIR_BIT]) begin
                    s_d.angle = s_q.angle == ANGLE_LAST ?
                        9'h000 : s_q.angle + 9'h001; // [R01]
                end else begin
                    s_d.angle = s_q.angle == 9'h000 ?
                        ANGLE_LAST : s_q.angle - 9'h001; // [R01]
                end
            end else begin
                s_d.sub = s_q.sub + 12'h001;
            end
        end

        // ----------
        // waveform results
        // ----------
        if (s_q.atc[ANG_WAVEFORM_ENABLE_A_BIT]) begin
            s_d.waveform_enable_a = wave_res; // [R07]
            if (s_q.atc[ANG_XFER_BIT]) begin
                s_d.duty = wave_res; // [R06]
            end
        end

        // ----------
        // register writes
        // ----------
        if (wr_en && acc_ok) begin
            unique case (idx)
                IDX_PD_CTRL_A: begin
                    s_d.pda = pwdata[5:0];
                    start = pwdata[PDA_START_BIT] || // [R19]
                        (pwdata[PDA_EN_BIT] && !s_q.pda[PDA_EN_BIT]); // [R24]
                    stop = pwdata[PDA_STOP_BIT]; // [R19]
                end
                IDX_PD_CTRL_B: s_d.pdb = pwdata[7:0];
                IDX_SMP_DELAY: s_d.sdl = pwdata[6:0];
                IDX_ANG_CTRL: begin
                    s_d.atc = pwdata[7:0]; // [R26]
                    if (!pwdata[ANG_EN_BIT]) begin
                        s_d.angle = 9'h000; // [R08]
                    end
                end
                IDX_ANG_PERIOD: s_d.aps = pwdata[15:0];
                IDX_ANG_VALUE: begin
                    // out-of-range angles are dropped
                    if (pwdata[8:0] <= ANGLE_LAST) begin
                        s_d.angle = pwdata[8:0];
                        s_d.sub = 12'h000;
                    end
                end
                IDX_AMPLITUDE: s_d.amp = pwdata[7:0];
                IDX_MOD_PERIOD: s_d.mod_prd = pwdata[15:0];
                IDX_REF_PAT: s_d.ref_pat = pwdata[2:0];
                default: ;
            endcase
        end

        // ----------
        // position detection
        // ----------
        start = start || (timer2_event && s_q.pda[PDA_T2_BIT]); // [R20]
        stop = stop || (timer3_event && s_q.pda[PDA_T3_BIT]); // [R20]
        pwm_rise = pwm_on && !s_q.pwm_on_q;
        mask = s_q.pda[PDA_ONEPIN_BIT] ? 3'b001 : 3'b111; // [R21]
        smp = {pos_in.w, pos_in.v, pos_in.u};
        need = s_q.pdb[3:0] == 4'h0 ? 4'h1 : s_q.pdb[3:0]; // [R18]
        unique case (madp_smp_mode_t'(s_q.pdb[PDB_MODE_LSB +: 2]))
            SMP_PWM_ON: gate = pwm_on; // [R17]
            SMP_ALWAYS: gate = 1'b1; // [R17]
            SMP_LOWER_ON: gate = lower_on; // [R17]
            SMP_RSVD: gate = 1'b0;
        endcase

        if (pwm_rise && s_q.mcnt != 4'h0) begin
            if (s_q.pda[PDA_RESTART_BIT]) begin
                s_d.mcnt = 4'h0; // [R22]
            end else begin
                s_d.carried = 1'b1; // [R22]
            end
        end

        unique case (s_q.pd)
            PD_IDLE: begin
                if (start && s_d.pda[PDA_EN_BIT] && !stop) begin
                    s_d.pd = PD_DELAY;
                    s_d.dly = {s_q.sdl, 3'b000}; // [R25]
                    s_d.mcnt = 4'h0;
                    s_d.carried = 1'b0;
                end
            end
            PD_DELAY: begin
                if (s_d.dly == 10'h000 || s_q.dly == 10'h001) begin
                    s_d.pd = PD_SAMPLE;
                    s_d.dly = 10'h000;
                end else begin
                    s_d.dly = s_q.dly - 10'h001; // [R25]
                end
            end
            PD_SAMPLE: begin
                if (smp_tick && gate) begin
                    if (s_q.pda[PDA_UNMATCH_BIT]) begin
                        s_d.unm = smp; // [R15] [R23]
                    end
                    // a sample unlike the reference counts as a match
                    if (((smp ^ s_q.ref_pat) & mask) != 3'b000) begin
                        s_d.mcnt = s_d.mcnt + 4'h1;
                        if (s_d.mcnt >= need) begin // [R18]
                            s_d.detect = 1'b1;
                            s_d.pd = PD_IDLE;
                            s_d.where = s_d.carried ? 2'b11 : 2'b00; // [R13]
                            s_d.ref_pat = smp;
                        end
                    end else begin
                        s_d.mcnt = 4'h0;
                        s_d.carried = 1'b0;
                    end
                end
            end
            default: s_d.pd = PD_IDLE;
        endcase

        if (stop || !s_d.pda[PDA_EN_BIT]) begin
            s_d.pd = PD_IDLE; // [R19] [R24]
            s_d.dly = 10'h000;
        end
    end

    // ----------
    // registers
    // ----------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.atc <= ANG_CTRL_RST;
            s_q.aps <= ANG_PERIOD_RST;
            s_q.pd <= PD_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign pwm_duty = s_q.duty;
    assign electrical_angle_value = s_q.angle;
    assign pos_detect = s_q.detect;
    assign sampling_active = s_q.pd != PD_IDLE;
endmodule : madp_core
`default_nettype wire

/* bench/madp_chk.sv */
// port-level assertions for the motor angle / position detect block
`timescale 1ns/1ps
`default_nettype none
module madp_chk import madp_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // results
    input wire madp_duty_t pwm_duty,
    input wire logic [8:0] electrical_angle_value,
    input wire logic pos_detect,
    input wire logic sampling_active
);
    logic wr;
    logic [13:0] idx;
    logic [8:0] ang;
    logic [7:0] ctl_q;
    assign wr = psel & penable & pready & pwrite;
    assign idx = paddr[15:2];
    assign ang = electrical_angle_value;
    // mirror of angle control, since the word itself is not a port
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_q <= 8'h00;
        end else if (wr && idx == IDX_ANG_CTRL) begin
            ctl_q <= pwdata[7:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_PREADY_ONE: assert property (
        psel && !penable |=> pready ##1 !pready
    ) else $error("pready not one cycle");
    AST_UNMAPPED_ERR: assert property (
        psel && !penable && idx == 14'h0000 |=> pslverr && prdata == 0
    ) else $error("unmapped access not refused");
    AST_ANG_CLEAR: assert property (
        wr && idx == IDX_ANG_CTRL && !pwdata[ANG_EN_BIT] |->
        ##[1:2] ang == 9'h000
    ) else $error("angle not cleared");
    AST_ANG_STEP: assert property (
        ctl_q[ANG_EN_BIT] && !$past(wr) && $changed(ang) |->
        ang == (ctl_q[ANG_DIR_BIT] ?
        ($past(ang) == 9'h000 ? ANGLE_LAST : $past(ang) - 9'h001) :
        ($past(ang) == ANGLE_LAST ? 9'h000 : $past(ang) + 9'h001))
    ) else $error("angle step wrong");
    AST_DETECT_PULSE: assert property (
        pos_detect |=> !pos_detect
    ) else $error("detect pulse too long");
    AST_SW_START: assert property (
        wr && idx == IDX_PD_CTRL_A && pwdata[6] && pwdata[0] && !pwdata[7]
        |=> sampling_active
    ) else $error("start bit ignored");
    AST_SW_STOP: assert property (
        wr && idx == IDX_PD_CTRL_A && pwdata[7] |=> !sampling_active
    ) else $error("stop bit ignored");
    AST_DUTY_HOLD: assert property (
        !ctl_q[ANG_XFER_BIT] && !$past(wr) |-> $stable(pwm_duty)
    ) else $error("duty moved without transfer");
    cover property (pos_detect);
    cover property (wr && idx == IDX_ANG_CTRL && pwdata[ANG_DIR_BIT]);
    cover property (pready && pslverr);
endmodule : madp_chk
bind madp_core madp_chk madp_chk_inst (.*);
`default_nettype wire

/* bench/madp_sensor_model.sv */
// far side: position sensors and inverter on/off state
`timescale 1ns/1ps
`default_nettype none
module madp_sensor_model import madp_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // bench control
    input wire logic run,
    input wire madp_pos_t pat,
    // pins
    output madp_pos_t pos_in,
    output logic pwm_on,
    output logic lower_on
);
    logic [5:0] ph_q;
    always_ff @(posedge ref_clk) begin
        ph_q <= rst ? 6'h00 : ph_q + 6'h01;
    end
    // push-pull sensors, latches already set to input use
    assign pos_in = pat;
    // bridge stopped: neither side conducts, so no pwm-on or lower-on sampling window
    assign pwm_on = run & ph_q[5];
    assign lower_on = run & ~ph_q[5];
endmodule : madp_sensor_model
`default_nettype wire

/* bench/madp_tb.sv */
// bench: apb tasks and test sequence for the angle / position block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
$display("[FAIL] %0t got %0h want %0h", $time, a, e); end end
module tb import madp_pkg::*; ;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic run = 0, t2 = 0, t3 = 0, pready, pslverr, pwm_on, lower_on;
    logic det, act, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [8:0] ang;
    logic [16:0] tv [3] = '{17'h0_0010, 17'h0_8005, 17'h1_0007};
    madp_pos_t pos_in, pat = 3'b000;
    madp_duty_t duty;
    int num_errors = 0, tests_run = 0, t;
    always #2.5 ref_clk = ~ref_clk;
    madp_sensor_model madp_sensor_model_inst (.ref_clk, .rst, .run, .pat,
        .pos_in, .pwm_on, .lower_on);
    madp_core madp_core_inst (.ref_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pos_in, .pwm_on,
        .lower_on, .timer2_event(t2), .timer3_event(t3), .pwm_duty(duty),
        .electrical_angle_value(ang), .pos_detect(det),
        .sampling_active(act));
    task automatic apb(input logic w, input logic [13:0] i,
            input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wdet(input int lim);
        t = 0;
        while (det !== 1'b1 && t < lim) begin
            @(posedge ref_clk);
            t++;
        end
    endtask : wdet
    task automatic steps(input int k);
        logic [8:0] a;
        for (int j = 0; j <= k; j++) begin
            a = ang;
            if (j == 1) t = 0;
            while (ang === a && t < 40000) begin
                @(posedge ref_clk);
                t++;
            end
        end
    endtask : steps
    task automatic sa(input logic e);
        repeat (2) @(posedge ref_clk);
        `CHK(act, e)
    endtask : sa
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (80000) @(posedge ref_clk);
        num_errors++;
        stop_test();
    end
    // ----------
    // tests
    // ----------
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 0;
        apb(0, IDX_ANG_CTRL, 0);
        `CHK(rd[7:0], ANG_CTRL_RST)
        apb(0, 14'h0000, 0);
        `CHK(err, 1'b1)
        apb(1, IDX_ANG_CTRL, 8'hf8);
        apb(0, IDX_ANG_CTRL, 0);
        `CHK(rd[7:0], 8'hf8)
        for (int c = 0; c < 4; c++) begin
            apb(1, IDX_ANG_CTRL, c << 4); // clock moved while stopped
            apb(1, IDX_ANG_PERIOD, (c * 5) << 12 | 16'h0010);
            apb(1, IDX_ANG_CTRL, c << 4 | 1);
            steps(16);
            `CHK(t, (256 + c * 5) * (8 << c))
            apb(1, IDX_ANG_CTRL, c << 4);
        end
        repeat (3) @(posedge ref_clk);
        `CHK(ang, 9'h000)
        apb(1, IDX_ANG_CTRL, 8'hb1);
        steps(0);
        `CHK(ang, ANGLE_LAST)
        apb(1, IDX_ANG_CTRL, 8'h30);
        apb(1, IDX_AMPLITUDE, 2);
        apb(1, IDX_MOD_PERIOD, 16'h0100);
        foreach (tv[i]) begin
            apb(1, IDX_ANG_VALUE, tv[i][16:8]);
            apb(1, IDX_SINE_PORT, tv[i][7:0]); // written blind
        end
        apb(1, IDX_ANG_VALUE, 0);
        apb(1, IDX_ANG_CTRL, 8'h32);
        apb(0, IDX_CMP_U, 0);
        `CHK(rd[15:0], 16'h0020)
        apb(0, IDX_CMP_W, 0);
        `CHK(rd[15:0], 16'h000e)
        `CHK(duty, 48'h0)
        apb(1, IDX_ANG_CTRL, 8'h72);
        apb(0, IDX_CMP_V, 0);
        `CHK(rd[15:0], 16'h000e)
        apb(1, IDX_ANG_CTRL, 8'h3e);
        apb(0, IDX_CMP_U, 0);
        `CHK(rd[15:0], 16'h0090)
        `CHK(duty.u, 16'h0090)
        apb(1, IDX_REF_PAT, 0);
        for (int c = 0; c < 4; c++) begin
            pat.u <= ~pat.u;
            apb(1, IDX_PD_CTRL_B, c << 6 | 8'h12);
            apb(1, IDX_PD_CTRL_A, 0);
            apb(1, IDX_PD_CTRL_A, 1);
            wdet(600);
            `CHK(t >= (4 << c) && t <= (8 << c) + 8, 1'b1)
        end
        pat <= 3'b010;
        apb(1, IDX_PD_CTRL_B, 8'h11);
        apb(1, IDX_PD_CTRL_A, 0);
        apb(1, IDX_PD_CTRL_A, 3);
        wdet(100);
        apb(0, IDX_PD_STATUS, 0);
        `CHK(rd[3:0], 4'b0010)
        pat <= 3'b011;
        apb(1, IDX_PD_CTRL_A, 0);
        apb(1, IDX_PD_CTRL_A, 8'h09);
        wdet(200);
        `CHK(t, 200)
        pat <= 3'b111;
        wdet(100);
        `CHK(det, 1'b1)
        apb(1, IDX_SMP_DELAY, 4);
        pat <= 3'b000;
        apb(1, IDX_PD_CTRL_A, 0);
        apb(1, IDX_PD_CTRL_A, 1);
        wdet(200);
        `CHK(t >= 32 && t <= 44, 1'b1)
        apb(1, IDX_SMP_DELAY, 0);
        apb(1, IDX_PD_CTRL_A, 8'h41);
        sa(1'b1);
        apb(1, IDX_PD_CTRL_A, 8'h81);
        sa(1'b0);
        apb(1, IDX_PD_CTRL_A, 8'h31);
        sa(1'b0);
        t2 <= 1;
        @(posedge ref_clk);
        t2 <= 0;
        sa(1'b1);
        t3 <= 1;
        @(posedge ref_clk);
        t3 <= 0;
        sa(1'b0);
        for (int m = 0; m < 3; m += 2) begin
            pat.u <= ~pat.u;
            run <= 0;
            apb(1, IDX_PD_CTRL_B, m << 4 | 1);
            apb(1, IDX_PD_CTRL_A, 0);
            apb(1, IDX_PD_CTRL_A, 1);
            wdet(150);
            `CHK(t, 150)
            run <= 1;
            wdet(300);
            `CHK(det, 1'b1)
        end
        stop_test();
    end
endmodule : tb
`default_nettype wire
